// file: aas_pkg.sv
// Shared constants, register map and carrier types of the converter autoscan sequencer
package aas_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH    = 8;
  localparam int RES_W  = 10;
  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RES_LOW0  = 8'h00;  // Lows at 0x00..0x07
  localparam logic [7:0] IDX_RES_HIGH  = 8'h08;
  localparam logic [7:0] IDX_CTRL      = 8'hD7;
  localparam logic [7:0] IDX_SCAN_SEL  = 8'hE7;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_DIV_HI = 7;
  localparam int CTRL_DIV_LO = 6;
  localparam int CTRL_RSVD   = 5;
  localparam int CTRL_DONE   = 4;
  localparam int CTRL_RUN    = 3;
  localparam int CTRL_CONT   = 2;
  localparam int CTRL_RISE   = 1;
  localparam int CTRL_FALL   = 0;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] SCAN_SEL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Prescaler: last count value for divide by 2, 4, 6, 8
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_LAST [4] = '{3'h1, 3'h3, 3'h5, 3'h7};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum {AAS_IDLE, AAS_SELECT, AAS_CONVERT} aas_state_e;

  typedef struct packed {
    logic [2:0] chan;
    logic       start;
  } aas_core_req_s;

  typedef struct packed {
    logic [1:0] div_sel;
    logic       cont;
    logic       rise_en;
    logic       fall_en;
  } aas_ctrl_s;

endpackage

// file: aas_sequencer.sv
// Autoscan sequencer: register slave, scan control, prescaler and result store
//
// What this block does
// RL1: Prescaler bits pick divide by 2, 4, 6, 8.
// RL2: Software writes zero to reserved control bit.
// RL3: Scan-done flag set after every selected input converted.
// RL4: Set scan-done flag with enable raises interrupt.
// RL5: Only software clears scan-done flag; never sets it.
// RL6: Setting run flag, software or pin, starts scan.
// RL7: Continuous mode keeps run flag after each loop.
// RL8: One-time mode clears run flag after last channel.
// RL9: Start requests ignored while run flag is one.
// RL10: Software clearing run flag aborts the conversion.
// RL11: Mode bit selects continuous or single scan.
// RL12: Enabled rising pin edge starts and captures.
// RL13: Enabled falling pin edge starts and captures.
// RL14: No start while scan select is all zero.
// RL15: Select write mid-loop applies to next loop.
// RL16: Select bit one includes channel, zero skips.
// RL17: Results read-only, untouched by reset.
// RL18: Low result register gives channel's low byte.
// RL19: Low read latches that channel's top two bits.
// RL20: High register shows latch bits, upper zero.
// RL21: Loop ascends from lowest selected channel.
// RL22: Start held pending while scan-done flag set.
// RL23: Reset clears the whole control register.
// RL24: Idle mode aborts, clears run, halts clock.
// RL25: Start pin passes two flops before edges.
// RL26: Drive core with channel, start; await done.
module aas_sequencer
  import aas_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  // Wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // System side
  input  wire logic              ext_start_pin,
  input  wire logic              idle_mode,
  input  wire logic              irq_en,
  output logic                   irq_o,
  output logic                   capture_o,
  // Analog core side
  output logic                   conv_clk_en,
  output logic      [2:0]        conv_chan,
  output logic                   conv_start,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_result
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aas_state_e       state, next_state;
  aas_ctrl_s        ctrl, next_ctrl;
  aas_core_req_s    core_req, next_core_req;
  logic [NCH-1:0]   scan_sel, next_scan_sel;
  logic [NCH-1:0]   rem, next_rem;
  logic             run, next_run;
  logic             done_flag, next_done_flag;
  logic             pend, next_pend;
  logic [2:0]       div_cnt, next_div_cnt;
  logic             clk_en, next_clk_en;
  logic             ack, next_ack;
  logic [31:0]      rdata, next_rdata;
  logic             irq, next_irq;
  logic             capture, next_capture;
  logic             sync1, sync2, pin_prev;
  logic [RES_W-1:0] res [NCH];
  logic [1:0]       hi_latch;

  // Decode and event terms
  logic [7:0]       idx;
  logic             wr, rd, wr_ctrl, wr_sel, rd_low;
  logic             ext_rise, ext_fall, ext_start, sw_start, sw_stop;
  logic             start_req, go, store_en, loop_end;
  logic [NCH-1:0]   rem_after;
  logic [2:0]       low_chan;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One request per cycle pair: the ack cycle itself is not a new request
  assign idx     = adr_i[ADDR_W-1:2];
  assign wr      = cyc_i && stb_i && we_i && !ack && sel_i[0];
  assign rd      = cyc_i && stb_i && !we_i && !ack;
  assign wr_ctrl = wr && (idx == IDX_CTRL);
  assign wr_sel  = wr && (idx == IDX_SCAN_SEL);
  assign rd_low  = rd && (idx < IDX_RES_HIGH);

  // ----------------------------------------------------------------
  // Start pin synchroniser and edge detect
  // ----------------------------------------------------------------
  // Only the second stage feeds the edge logic, so one edge is one request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1    <= 1'b0;
      sync2    <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      sync1    <= ext_start_pin;  // [RL25]
      sync2    <= sync1;          // [RL25]
      pin_prev <= sync2;
    end
  end

  assign ext_rise  = sync2 && !pin_prev;
  assign ext_fall  = !sync2 && pin_prev;
  assign ext_start = (ext_rise && ctrl.rise_en)   // [RL12]
                   || (ext_fall && ctrl.fall_en); // [RL13]

  // ----------------------------------------------------------------
  // Start, stop and loop events
  // ----------------------------------------------------------------
  assign sw_start  = wr_ctrl && dat_i[CTRL_RUN];
  assign sw_stop   = wr_ctrl && !dat_i[CTRL_RUN] && run;
  // A running scan swallows further starts
  assign start_req = (sw_start || ext_start) && !run;  // [RL6] [RL9]
  // Pending or fresh start only fires once the done flag is clear
  assign go        = (start_req || pend) && !done_flag  // [RL22]
                   && (scan_sel != '0)                // [RL14]
                   && !idle_mode;
  assign store_en  = (state == AAS_CONVERT) && conv_done
                   && !idle_mode && !sw_stop;           // [RL26]
  assign rem_after = rem & ~(NCH'(1) << core_req.chan);
  assign loop_end  = store_en && (rem_after == '0);

  // Lowest remaining channel; loop runs downward so the lowest wins
  always_comb begin
    low_chan = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (rem[i]) begin
        low_chan = 3'(i);  // [RL21]
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, flags and sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl      = ctrl;
    next_scan_sel  = scan_sel;
    next_state     = state;
    next_rem       = rem;
    next_run       = run;
    next_pend      = pend;
    next_done_flag = done_flag;
    next_core_req  = '{chan: core_req.chan, start: 1'b0};

    // Plain configuration fields; reserved bit is not stored
    if (wr_ctrl) begin
      next_ctrl.div_sel = dat_i[CTRL_DIV_HI:CTRL_DIV_LO];  // [RL1]
      next_ctrl.cont    = dat_i[CTRL_CONT];                // [RL11]
      next_ctrl.rise_en = dat_i[CTRL_RISE];
      next_ctrl.fall_en = dat_i[CTRL_FALL];
    end
    if (wr_sel) begin
      next_scan_sel = dat_i[NCH-1:0];  // [RL16]
    end

    // Writing zero clears; writing one does nothing; a set wins
    if (wr_ctrl && !dat_i[CTRL_DONE]) begin
      next_done_flag = 1'b0;  // [RL5]
    end
    if (loop_end) begin
      next_done_flag = 1'b1;  // [RL3]
    end

    // Start arriving under a set done flag is remembered
    if (start_req && done_flag) begin
      next_pend = 1'b1;  // [RL22]
    end

    // Sequencer proper
    case (state)
      AAS_SELECT: begin
        next_core_req = '{chan: low_chan, start: !sw_stop && !idle_mode};  // [RL26]
        next_state    = AAS_CONVERT;
      end
      AAS_CONVERT: begin
        if (store_en) begin
          next_rem = rem_after;
          if (!loop_end) begin
            next_state = AAS_SELECT;  // [RL21]
          end else if (ctrl.cont && (scan_sel != '0)) begin
            next_rem   = scan_sel;    // [RL7] [RL15]
            next_state = AAS_SELECT;
          end else begin
            next_run   = 1'b0;        // [RL8]
            next_state = AAS_IDLE;
          end
        end
      end
      default: begin
        if (go) begin
          // Selection is copied here so mid-loop writes wait a loop
          next_run   = 1'b1;          // [RL6]
          next_pend  = 1'b0;
          next_rem   = scan_sel;      // [RL15]
          next_state = AAS_SELECT;
        end
      end
    endcase

    // Abort paths override the sequencer; the done flag is left alone
    if (sw_stop) begin
      next_run   = 1'b0;  // [RL10]
      next_state = AAS_IDLE;
    end
    if (idle_mode) begin
      next_run   = 1'b0;  // [RL24]
      next_pend  = 1'b0;
      next_state = AAS_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl      <= aas_ctrl_s'(5'h00);  // [RL23]
      scan_sel  <= SCAN_SEL_RST;
      state     <= AAS_IDLE;
      rem       <= '0;
      run       <= CTRL_RST[CTRL_RUN];  // [RL23]
      pend      <= 1'b0;
      done_flag <= CTRL_RST[CTRL_DONE]; // [RL23]
      core_req  <= '0;
    end else begin
      ctrl      <= next_ctrl;
      scan_sel  <= next_scan_sel;
      state     <= next_state;
      rem       <= next_rem;
      run       <= next_run;
      pend      <= next_pend;
      done_flag <= next_done_flag;
      core_req  <= next_core_req;
    end
  end

  assign conv_chan  = core_req.chan;
  assign conv_start = core_req.start;

  // ----------------------------------------------------------------
  // Converter clock prescaler
  // ----------------------------------------------------------------
  // Counter rests at zero when idle, so the clock really halts
  always_comb begin
    next_div_cnt = 3'h0;
    next_clk_en  = 1'b0;
    if ((state != AAS_IDLE) && !idle_mode) begin
      if (div_cnt >= DIV_LAST[ctrl.div_sel]) begin
        next_clk_en = 1'b1;  // [RL1]
      end else begin
        next_div_cnt = div_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 3'h0;
      clk_en  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clk_en  <= next_clk_en;  // [RL24]
    end
  end

  assign conv_clk_en = clk_en;

  // ----------------------------------------------------------------
  // Result store and high-bit latch
  // ----------------------------------------------------------------
  // No reset on purpose: contents survive chip reset
  always_ff @(posedge clk) begin
    if (store_en) begin
      res[core_req.chan] <= conv_result;  // [RL17] [RL26]
    end
    if (rd_low) begin
      hi_latch <= res[idx[2:0]][RES_W-1:8];  // [RL19]
    end
  end

  // ----------------------------------------------------------------
  // Bus answer, interrupt and capture outputs
  // ----------------------------------------------------------------
  // Every access is acked one cycle later; unmapped reads give zero
  always_comb begin
    next_ack     = cyc_i && stb_i && !ack;
    next_rdata   = 32'h0000_0000;
    next_irq     = done_flag && irq_en;  // [RL4]
    next_capture = ext_start;            // [RL12] [RL13]
    if (rd) begin
      if (rd_low) begin
        next_rdata[7:0] = res[idx[2:0]][7:0];  // [RL18]
      end else if (idx == IDX_RES_HIGH) begin
        next_rdata[1:0] = hi_latch;             // [RL20]
      end else if (idx == IDX_CTRL) begin
        // Run reads as the effective state, so a pending start shows zero
        next_rdata[7:0] = {ctrl.div_sel, 1'b0, done_flag, run,
                           ctrl.cont, ctrl.rise_en, ctrl.fall_en};
      end else if (idx == IDX_SCAN_SEL) begin
        next_rdata[7:0] = scan_sel;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack     <= 1'b0;
      rdata   <= 32'h0000_0000;
      irq     <= 1'b0;
      capture <= 1'b0;
    end else begin
      ack     <= next_ack;
      rdata   <= next_rdata;
      irq     <= next_irq;
      capture <= next_capture;
    end
  end

  assign ack_o     = ack;
  assign dat_o     = rdata;
  assign irq_o     = irq;
  assign capture_o = capture;

  // ----------------------------------------------------------------
  // Assertions and cover points
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_div_wrap_pulse: assert property (
    (state != AAS_IDLE) && !idle_mode && (div_cnt == DIV_LAST[ctrl.div_sel])
    |=> conv_clk_en ##1 !conv_clk_en)  // [RL1]
    else $error("prescaler did not pulse at terminal count");

  a_done_on_loop: assert property (loop_end |=> done_flag)  // [RL3]
    else $error("scan-done flag not set after last channel");

  a_irq_follows: assert property (done_flag && irq_en |=> irq_o)  // [RL4]
    else $error("interrupt request missing");

  a_done_sticky: assert property (
    done_flag && !(wr_ctrl && !dat_i[CTRL_DONE]) |=> done_flag)  // [RL5]
    else $error("scan-done flag cleared without software");

  a_done_no_sw_set: assert property (
    !done_flag && !loop_end |=> !done_flag)  // [RL5]
    else $error("scan-done flag set by something other than a loop");

  a_cont_keeps_run: assert property (
    loop_end && ctrl.cont && (scan_sel != '0) && !idle_mode
    |=> run && (state == AAS_SELECT))  // [RL7]
    else $error("continuous scan stopped after loop");

  a_single_stops: assert property (
    loop_end && !ctrl.cont |=> !run && (state == AAS_IDLE))  // [RL8]
    else $error("one-time scan kept running");

  a_sw_abort: assert property (sw_stop |=> (!run && !conv_start) ##1 !conv_start)  // [RL10]
    else $error("software stop did not abort");

  a_zero_select: assert property (
    (scan_sel == '0) && !run |=> !run)  // [RL14]
    else $error("scan started with empty selection");

  a_pend_holds: assert property (
    start_req && done_flag && !idle_mode |=> !run && pend)  // [RL22]
    else $error("start under set done flag not held pending");

  a_idle_halts: assert property (
    idle_mode |=> !run && !conv_clk_en && (state == AAS_IDLE))  // [RL24]
    else $error("idle mode did not halt converter");

  a_capture_edge: assert property (
    ext_rise && ctrl.rise_en |=> capture_o)  // [RL12]
    else $error("rising edge capture missing");

  a_hi_latch_copy: assert property (
    rd_low |=> hi_latch == $past(res[idx[2:0]][RES_W-1:8]))  // [RL19]
    else $error("high bits not latched on low read");

  a_hi_upper_zero: assert property (
    rd && (idx == IDX_RES_HIGH) |=> ack_o && (dat_o[31:2] == '0))  // [RL20]
    else $error("high register upper bits not zero");

  c_single_scan: cover property (loop_end && !ctrl.cont);
  c_cont_scan:   cover property (loop_end && ctrl.cont);
  c_ext_start:   cover property (ext_start && go);
  c_pend_start:  cover property (pend && go);

endmodule

// file: aas_core_model.sv
// Behavioural model of the analog converter core that faces the sequencer
module aas_core_model
  import aas_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             conv_start,
  input  wire logic [2:0]       conv_chan,
  input  wire logic [4:0]       delay,
  output logic                  conv_done,
  output logic      [RES_W-1:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] seq;
  logic [4:0] cnt;
  logic [2:0] chan;
  logic       busy;

  // ----------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------
  // One conversion at a time; a new start restarts the wait
  // The result bus toggles outside the done strobe so stale data never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seq         <= 5'h00;
      cnt         <= 5'h00;
      chan        <= 3'h0;
      busy        <= 1'b0;
      conv_done   <= 1'b0;
      conv_result <= 10'h155;
    end else begin
      conv_done   <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy <= 1'b1;
        cnt  <= delay;
        chan <= conv_chan;
      end else if (busy && cnt == 5'h00) begin
        busy        <= 1'b0;
        conv_done   <= 1'b1;
        conv_result <= {seq[1:0], seq, chan};  // Sequence number tags the order
        seq         <= seq + 5'h01;
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

// file: test_aas_sequencer.sv
// Self-checking bench for the autoscan sequencer with a behavioural core
module test_aas_sequencer
  import aas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, rst, cyc_i, stb_i, we_i, ack_o, ext_start_pin, idle_mode;
  logic              irq_en, irq_o, capture_o, conv_clk_en, conv_start, conv_done;
  logic [ADDR_W-1:0] adr_i;
  logic [3:0]        sel_i;
  logic [31:0]       dat_i, dat_o, c;
  logic [2:0]        conv_chan;
  logic [RES_W-1:0]  conv_result;
  logic [4:0]        delay, base;
  logic [7:0]        s;
  logic [32:0]       note;
  logic [32:0]       exp_q[$];
  int                miscompares, num_checks, cap_cnt, start_cnt, en_cnt, seed, n0;
  time               t_prev, t_last;

  // Free running clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  aas_sequencer uut (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_start_pin(ext_start_pin), .idle_mode(idle_mode), .irq_en(irq_en), .irq_o(irq_o),
    .capture_o(capture_o), .conv_clk_en(conv_clk_en), .conv_chan(conv_chan),
    .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result));
  aas_core_model core (.clk(clk), .rst(rst), .conv_start(conv_start), .conv_chan(conv_chan),
    .delay(delay), .conv_done(conv_done), .conv_result(conv_result));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s, seen %h, expected %h", $time, msg, seen, exp);
    end
  endtask

  // Read notes are taken oldest first as each read ack appears; events are counted
  always @(posedge clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[32]) check(dat_o, note[31:0], "read data");
    end
    if (capture_o === 1'b1) cap_cnt++;
    if (conv_start === 1'b1) start_cnt++;
    if (conv_clk_en === 1'b1) begin
      en_cnt++;
      t_prev = t_last;
      t_last = $time;
    end
  end

  // Classic single cycle: request held until ack is sampled, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n == 20) check(32'h0, 32'h1, "no bus ack");
    c = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [7:0] idx, input logic chk, input logic [31:0] exp);
    exp_q.push_back({chk, exp});
    bus(1'b0, idx, 8'h00);
  endtask

  // Poll the control register; bounded so a missing flag shows as a mismatch later
  task automatic wait_done();
    for (int k = 0; k < 400; k++) begin
      rd(IDX_CTRL, 1'b0, 32'h0);
      if (c[CTRL_DONE] === 1'b1) break;
    end
  endtask

  task automatic idle_pulse();
    idle_mode <= 1'b1;
    repeat (2) @(posedge clk);
    idle_mode <= 1'b0;
    @(posedge clk);
  endtask

  // One-time scan of selection s, then every selected result read back
  task automatic scan_once();
    delay <= 5'(($random(seed) & 15) + 1);
    wr(IDX_SCAN_SEL, s);
    base = core.seq;
    wr(IDX_CTRL, 8'h08); // Reserved bit kept at zero
    wait_done();
    check(c, 32'h10, "one-time end state");
    check(irq_o, 1'b1, "irq with flag set");
    wr(IDX_RES_LOW0, 8'hFF); // Must be dropped
    for (int ch = 0; ch < NCH; ch++) begin
      if (s[ch]) begin
        rd(8'(ch), 1'b1, {24'h0, base, 3'(ch)});
        rd(IDX_RES_HIGH, 1'b1, {30'h0, base[1:0]});
        base++;
      end
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, irq_en} = 2'b11;
    {cyc_i, stb_i, we_i, ext_start_pin, idle_mode} = 5'h00;
    {adr_i, dat_i, sel_i, delay} = {10'h000, 32'h0, 4'hF, 5'h04};
    miscompares = 0;
    num_checks  = 0;
    cap_cnt     = 0;
    start_cnt   = 0;
    en_cnt      = 0;
    t_prev      = 0;
    t_last      = 0;
    seed        = 22109;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL, 1'b1, 32'h0);
    rd(IDX_SCAN_SEL, 1'b1, 32'h0);
    rd(8'h40, 1'b1, 32'h0);
    wr(IDX_CTRL, 8'h08);
    rd(IDX_CTRL, 1'b1, 32'h0); // Empty selection refuses the start
    $display("test reset and empty selection done");
    for (int i = 0; i < 5; i++) begin
      s = (i == 0) ? 8'h05 : (i == 1) ? 8'h80 : (i == 2) ? 8'hFF : 8'($random(seed));
      if (s == 8'h00) s = 8'h01;
      scan_once();
      wr(IDX_CTRL, 8'h18);
      rd(IDX_CTRL, 1'b1, 32'h10); // Start held while flag is up
      idle_pulse();
      rd(IDX_CTRL, 1'b1, 32'h10);
      wr(IDX_CTRL, 8'h10);
      rd(IDX_CTRL, 1'b1, 32'h10);
      wr(IDX_CTRL, 8'h00);
      rd(IDX_CTRL, 1'b1, 32'h00);
      check(irq_o, 1'b0, "irq follows flag");
    end
    $display("test one-time scans done");
    wr(IDX_SCAN_SEL, 8'h03);
    wr(IDX_CTRL, 8'h0C);
    wait_done();
    check(c, 32'h1C, "continuous keeps run");
    wr(IDX_SCAN_SEL, 8'h40);
    for (int k = 0; k < 300 && !(conv_start === 1'b1 && conv_chan === 3'h6); k++) @(posedge clk);
    check(conv_chan, 3'h6, "new selection on a later loop");
    wr(IDX_CTRL, 8'h04);
    rd(IDX_CTRL, 1'b1, 32'h04);
    n0 = start_cnt;
    repeat (60) @(posedge clk);
    check(start_cnt - n0, 0, "no start after abort");
    $display("test continuous and abort done");
    wr(IDX_SCAN_SEL, 8'h01);
    for (int d = 0; d < 4; d++) begin
      wr(IDX_CTRL, {2'(d), 6'h0C});
      repeat (40) @(posedge clk);
      check(32'(t_last - t_prev), 32'(20 * (d + 1)), "clock enable spacing");
    end
    idle_mode <= 1'b1;
    repeat (2) @(posedge clk); // The pulse launched before idle took hold is not counted
    n0 = en_cnt;
    repeat (20) @(posedge clk);
    check(en_cnt - n0, 0, "clock halted in idle");
    idle_mode <= 1'b0;
    @(posedge clk);
    rd(IDX_CTRL, 1'b0, 32'h0);
    check(c & 32'h08, 32'h0, "idle clears run");
    wr(IDX_CTRL, 8'h00);
    $display("test prescaler and idle done");
    for (int e = 0; e < 4; e++) begin
      wr(IDX_CTRL, 8'(e));
      n0 = cap_cnt;
      ext_start_pin <= 1'b1;
      repeat (40) @(posedge clk);
      ext_start_pin <= 1'b0;
      repeat (40) @(posedge clk);
      check(cap_cnt - n0, e / 2 + e % 2, "captures per pin pulse");
      rd(IDX_CTRL, 1'b1, {27'h0, e != 0, 2'b00, 2'(e)});
      idle_pulse();
      wr(IDX_CTRL, 8'h00);
    end
    $display("test start pin done");
    test_done();
  end

  // Watchdog at 20,000 cycles, several times what the whole sequence needs
  initial begin
    #200us;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
